//--- src/fpi_host.sv
/*
 Host controller driving a page flash through its strobe pins.
 Assumes ready/busy is pulled up externally and that the device
 follows its own pin protocol. One request per bus cycle.
*/
`timescale 1ns/1ps
module fpi_host #(
	parameter int DATA_W     = fpi_pkg::DATA_W,
	parameter int FIFO_DEPTH = fpi_pkg::FIFO_DEPTH
) (
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst,
	input  wire logic              i_wide,
	input  wire logic              i_wp_release,
	input  wire logic              i_req_valid,
	output logic                   o_req_ready,
	input  wire fpi_pkg::fpi_req_s i_req,
	output logic                   o_rd_valid,
	input  wire logic              i_rd_ready,
	output logic      [DATA_W-1:0] o_rd_data,
	output logic                   o_busy,
	output fpi_pkg::fpi_ctl_s      o_ctl,
	output logic      [15:0]       o_io,
	output logic      [15:0]       o_io_oe_n,
	input  wire logic [15:0]       i_io,
	input  wire logic              i_ready_busy
);
	typedef enum logic [2:0] {
		FPI_ST_RECOVER = 3'b000,
		FPI_ST_IDLE    = 3'b001,
		FPI_ST_SETUP   = 3'b010,
		FPI_ST_STROBE  = 3'b011,
		FPI_ST_HOLD    = 3'b100
	} fpi_state_e;

	fpi_state_e        state;
	fpi_pkg::fpi_req_s cur;
	logic [9:0]        cnt;
	logic [2:0]        rb_sync;
	logic              rb_ready;
	logic              fifo_in_ready;
	logic              fifo_push;
	logic              fifo_valid;
	logic [DATA_W-1:0] fifo_data;

	function automatic logic is_read(input logic [1:0] op);
		return op == fpi_pkg::OP_RDATA;
	endfunction

	// Three-stage sync; a change counts only when stages two and three agree
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rb_sync  <= 3'h7;
			rb_ready <= 1'b1;
		end else begin
			rb_sync <= {rb_sync[1:0], i_ready_busy};
			if (rb_sync[1] == rb_sync[2]) begin
				rb_ready <= rb_sync[2];
			end
		end
	end

	// Read captures need FIFO room, so a stalled consumer stalls the bus
	// Waits for the registered busy flag too, so ready never leads it
	assign o_req_ready = (state == FPI_ST_IDLE) && rb_ready && !o_busy &&
		(!is_read(i_req.op) || fifo_in_ready);

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state <= FPI_ST_RECOVER;
			cnt   <= '0;
			cur   <= '0;
		end else begin
			unique case (state)
			FPI_ST_RECOVER: begin
				// Write strobe stays high and no command goes out meanwhile
				cnt <= cnt + 1'b1;
				if (cnt == 10'(fpi_pkg::RECOVERY_CYC - 1)) begin
					state <= FPI_ST_IDLE;
					cnt   <= '0;
				end
			end
			FPI_ST_IDLE: begin
				if (i_req_valid && o_req_ready) begin
					cur   <= i_req;
					state <= FPI_ST_SETUP;
				end
			end
			FPI_ST_SETUP: begin
				state <= FPI_ST_STROBE;
			end
			FPI_ST_STROBE: begin
				cnt <= cnt + 1'b1;
				if (cnt == 10'(fpi_pkg::STROBE_CYC - 1)) begin
					cnt   <= '0;
					state <= FPI_ST_HOLD;
				end
			end
			FPI_ST_HOLD: begin
				cnt <= cnt + 1'b1;
				if (cnt == 10'(fpi_pkg::STROBE_CYC - 1)) begin
					cnt   <= '0;
					state <= FPI_ST_IDLE;
				end
			end
			default: state <= FPI_ST_IDLE;
			endcase
		end
	end

	// Pin drive: registered so every output comes straight from a flop
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_ctl     <= '{cs_n: 1'b1, cmd_latch_sel: 1'b0,
				addr_latch_sel: 1'b0, we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0};
			o_io      <= 16'h0000;
			o_io_oe_n <= 16'hffff;
		end else begin
			// Protection held through recovery, then follows software
			o_ctl.wp_n <= (state != FPI_ST_RECOVER) && i_wp_release;
			o_ctl.we_n <= !(state == FPI_ST_STROBE && !is_read(cur.op));
			o_ctl.re_n <= !(state == FPI_ST_STROBE && is_read(cur.op));
			if (state == FPI_ST_SETUP) begin
				o_ctl.cs_n           <= 1'b0;
				o_ctl.cmd_latch_sel  <= (cur.op == fpi_pkg::OP_CMD);
				o_ctl.addr_latch_sel <= (cur.op == fpi_pkg::OP_ADDR);
				o_io <= (cur.op == fpi_pkg::OP_WDATA && i_wide) ?
					cur.data : {8'h00, cur.data[7:0]};
				o_io_oe_n[7:0]  <= {8{is_read(cur.op)}};
				o_io_oe_n[15:8] <= {8{is_read(cur.op) || !i_wide ||
					cur.op != fpi_pkg::OP_WDATA}};
			end else if (state == FPI_ST_IDLE && !rb_ready) begin
				// Deselect only when asked; held low to keep row reads alive
				o_ctl.cs_n <= !cur.hold_cs;
			end else if (state == FPI_ST_IDLE && !cur.hold_cs) begin
				o_ctl.cs_n           <= 1'b1;
				o_ctl.cmd_latch_sel  <= 1'b0;
				o_ctl.addr_latch_sel <= 1'b0;
				o_io_oe_n            <= 16'hffff;
			end else if (state == FPI_ST_HOLD && cnt == 10'h001) begin
				// One cycle after the strobe rises so the latch sees stable selects
				o_ctl.cmd_latch_sel  <= 1'b0;
				o_ctl.addr_latch_sel <= 1'b0;
			end
		end
	end

	// Sample data just before read strobe rises; device drives until then
	assign fifo_push = (state == FPI_ST_STROBE) && is_read(cur.op) &&
		(cnt == 10'(fpi_pkg::STROBE_CYC - 1));

	fpi_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_ref_clk   (i_ref_clk),
		.i_rst       (i_rst),
		.i_in_valid  (fifo_push),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (i_wide ? i_io[DATA_W-1:0] :
			DATA_W'(i_io[7:0])),
		.o_out_valid (fifo_valid),
		.i_out_ready (i_rd_ready && o_rd_valid),
		.o_out_data  (fifo_data)
	);

	// Output register stage in front of the FIFO head
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_rd_valid <= 1'b0;
			o_rd_data  <= '0;
			o_busy     <= 1'b1;
		end else begin
			o_busy <= !rb_ready || state == FPI_ST_RECOVER;
			if (!o_rd_valid || i_rd_ready) begin
				o_rd_valid <= fifo_valid && !(o_rd_valid && i_rd_ready);
				o_rd_data  <= fifo_data;
			end
		end
	end
endmodule

//--- src/fpi_pkg.sv
/*
 Constants and carrier types for the flash page pin host controller.
 Assumes a single 250 MHz clock and an external pull-up on ready/busy.
*/
// Contract
// - High lanes carry data only; commands and addresses use low lanes.
// - Sequential row read: keep chip select low during busy, else abort.
// - Host waits at least 1 us after power change, write strobe high.
// - Host holds write protect low during power ramps.
// - Ready/busy is shared open-drain; low means some device busy.
// - Command: chip select low, cmd high, addr low, read strobe high.
// - Address takes three cycles small densities, four cycles large.
package fpi_pkg;
	localparam int    CLK_MHZ         = 250;
	localparam int    PAGES_PER_BLOCK = 32;
	localparam int    HALF_PAGE_BYTES = 256;
	localparam int    SPARE_BYTES     = 16;
	localparam int    MAIN_WORDS      = 256;
	localparam int    SPARE_WORDS     = 8;
	localparam int    RECOVERY_NS     = 1000;
	localparam int    RECOVERY_CYC    = (RECOVERY_NS * CLK_MHZ + 999) / 1000;
	localparam int    STROBE_CYC      = 8;
	localparam int    ADDR_CYC_SMALL  = 3;
	localparam int    ADDR_CYC_LARGE  = 4;
	localparam int    FIFO_DEPTH      = 16;
	localparam int    DATA_W          = 16;
	localparam logic [1:0] OP_CMD     = 2'h0;
	localparam logic [1:0] OP_ADDR    = 2'h1;
	localparam logic [1:0] OP_WDATA   = 2'h2;
	localparam logic [1:0] OP_RDATA   = 2'h3;

	typedef struct packed {
		logic [1:0]  op;
		logic        hold_cs;
		logic [15:0] data;
	} fpi_req_s;

	typedef struct packed {
		logic        cs_n;
		logic        cmd_latch_sel;
		logic        addr_latch_sel;
		logic        we_n;
		logic        re_n;
		logic        wp_n;
	} fpi_ctl_s;
endpackage

//--- src/fpi_fifo.sv
/*
 Parameterised valid/ready FIFO for read data returning from the flash.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module fpi_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign o_in_ready  = (count != (AW+1)'(DEPTH));
	assign o_out_valid = (count != '0);
	assign o_out_data  = mem[rd_ptr];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_ff @(posedge i_ref_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

//--- sim/fpi_host_asserts.sv
/*
 Pin protocol checker for the flash host controller.
 Assumes it is bound to fpi_host and sees only its ports.
*/
`timescale 1ns/1ps
module fpi_host_asserts (
	input wire logic              i_ref_clk,
	input wire logic              i_rst,
	input wire logic              i_wp_release,
	input wire logic              o_req_ready,
	input wire logic              o_busy,
	input wire fpi_pkg::fpi_ctl_s o_ctl,
	input wire logic [15:0]       o_io,
	input wire logic [15:0]       o_io_oe_n
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	logic [9:0] since;
	// Saturates so a long run never wraps back into the recovery window
	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			since <= '0;
		else if (since != 10'h3ff)
			since <= since + 10'h001;
	end
	chk_latch_excl: assert property (!(o_ctl.cmd_latch_sel && o_ctl.addr_latch_sel)) else $error("both latch selects high");
	chk_strobe_excl: assert property (!(!o_ctl.we_n && !o_ctl.re_n)) else $error("both strobes low");
	chk_strobe_sel: assert property ((!o_ctl.we_n || !o_ctl.re_n) |-> !o_ctl.cs_n) else $error("strobe while deselected");
	chk_ready_idle: assert property (o_req_ready |-> !o_busy) else $error("ready while busy");
	chk_read_release: assert property (!o_ctl.re_n |-> &o_io_oe_n && !o_ctl.cmd_latch_sel) else $error("host drives during read");
	chk_strobe_len: assert property ($fell(o_ctl.we_n) |-> (!o_ctl.we_n)[*8] ##1 o_ctl.we_n) else $error("write strobe length");
	chk_capture_hold: assert property ($rose(o_ctl.we_n) |-> $stable(o_io) && $stable(o_ctl.cmd_latch_sel)) else $error("capture unstable");
	chk_wp_follow: assert property ($fell(i_wp_release) |-> ##[1:3] !o_ctl.wp_n) else $error("protect not applied");
	chk_recovery_wait: assert property (since < 10'h0fa |-> !o_req_ready && !o_ctl.wp_n) else $error("request in recovery");
	cover property ($fell(o_ctl.re_n));
	cover property ($fell(o_ctl.we_n) && o_ctl.cmd_latch_sel);
	cover property ($rose(o_busy));
endmodule

//--- sim/fpi_flash_model.sv
/*
 Behavioural page flash device for the host bench.
 Assumes a pulled-up ready/busy line; returns the resolved lane level.
*/
`timescale 1ns/1ps
module fpi_flash_model #(
	parameter logic [15:0] PATTERN = 16'ha500,
	parameter int          BUSY_NS = 400
) (
	input  wire fpi_pkg::fpi_ctl_s i_ctl,
	input  wire logic [15:0]       i_host_io,
	input  wire logic [15:0]       i_host_oe_n,
	output logic      [15:0]       o_bus,
	output logic                   o_ready_busy
);
	logic [15:0] col = '0;
	logic [15:0] dout = '0;
	logic        busy = 1'b0;
	logic        dev_oe;
	assign dev_oe = !i_ctl.cs_n && i_ctl.we_n && !i_ctl.re_n && !i_ctl.cmd_latch_sel && !i_ctl.addr_latch_sel;
	// Undriven lanes show the inverse so a stale value never matches
	assign o_bus = ~i_host_oe_n & i_host_io | i_host_oe_n & (dev_oe ? dout : ~dout);
	assign o_ready_busy = !busy;
	always @(posedge i_ctl.we_n) begin
		if (!i_ctl.cs_n && i_ctl.cmd_latch_sel) begin
			col = '0;
			if (i_host_io[7] && i_ctl.wp_n)
				busy = 1'b1;
		end
	end
	always @(posedge busy) begin
		#(BUSY_NS);
		busy = 1'b0;
	end
	always @(negedge i_ctl.re_n) begin
		if (!i_ctl.cs_n) begin
			dout = PATTERN ^ col;
			// Column wraps at the end of the page, spare area included
			if (col == 16'(2 * fpi_pkg::HALF_PAGE_BYTES + fpi_pkg::SPARE_BYTES - 1))
				col = '0;
			else
				col = col + 16'h0001;
		end
	end
endmodule

//--- sim/tb.sv
/*
 Self-checking bench for the flash host controller and device model.
 Assumes the design package and modules are compiled first.
*/
`timescale 1ns/1ps
module tb;
	localparam logic [15:0] PAT = 16'ha500;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic              wide = 1'b0;
	logic              wpr = 1'b0;
	logic              rv = 1'b0;
	logic              rr = 1'b1;
	logic              ready, rd_valid, busy, rb;
	logic [15:0]       rdata, io, oe_n, bus;
	logic [15:0]       col = '0;
	logic [31:0]       e;
	logic [17:0]       w;
	fpi_pkg::fpi_req_s req = '0;
	fpi_pkg::fpi_ctl_s ctl;
	logic [31:0]       rd_q[$];
	logic [17:0]       wr_q[$];
	int                n, errors = 0, num_checks = 0;
	always #2 clk = ~clk;
	fpi_host u_fpi_host (.i_ref_clk(clk), .i_rst(rst), .i_wide(wide),
		.i_wp_release(wpr), .i_req_valid(rv), .o_req_ready(ready),
		.i_req(req), .o_rd_valid(rd_valid), .i_rd_ready(rr),
		.o_rd_data(rdata), .o_busy(busy), .o_ctl(ctl), .o_io(io),
		.o_io_oe_n(oe_n), .i_io(bus), .i_ready_busy(rb));
	fpi_flash_model #(.PATTERN(PAT)) u_fpi_flash_model (.i_ctl(ctl),
		.i_host_io(io), .i_host_oe_n(oe_n), .o_bus(bus), .o_ready_busy(rb));
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic send(input logic [1:0] op, input logic [15:0] d);
		int          k = 0;
		logic [15:0] m = (wide && op[1]) ? 16'hffff : 16'h00ff;
		@(negedge clk);
		req = '{op, 1'b1, d};
		rv = 1'b1;
		while (!ready && k < 5000) begin
			@(negedge clk);
			k++;
		end
		if (k == 5000)
			errors++;
		if (op == fpi_pkg::OP_RDATA)
			rd_q.push_back({m, (PAT ^ col++) & m});
		else
			wr_q.push_back({op == fpi_pkg::OP_CMD, op == fpi_pkg::OP_ADDR, d & m});
		if (op == fpi_pkg::OP_CMD)
			col = '0;
		@(negedge clk);
		rv = 1'b0;
	endtask
	always @(posedge clk) begin
		if (rd_valid && rr) begin
			e = rd_q.pop_front();
			check({2'b00, rdata & e[31:16]}, {2'b00, e[15:0]});
		end
	end
	always @(posedge ctl.we_n) begin
		if (!ctl.cs_n && !rst) begin
			w = wr_q.pop_front();
			check({ctl.cmd_latch_sel, ctl.addr_latch_sel, bus & ((w[17] | w[16] | !wide) ? 16'h00ff : 16'hffff)}, w);
		end
	end
	initial begin
		void'($urandom(28));
		repeat (10) @(negedge clk);
		check({17'h0_0000, ctl.wp_n}, 18'h0_0000);
		rst = 1'b0;
		n = 0;
		while (!ready) begin
			@(negedge clk);
			n++;
		end
		check({17'h0_0000, n >= fpi_pkg::RECOVERY_CYC}, 18'h0_0001);
		wpr = 1'b1;
		send(fpi_pkg::OP_CMD, 16'($urandom) & 16'h007f);
		repeat (3) send(fpi_pkg::OP_ADDR, 16'($urandom));
		repeat (4) send(fpi_pkg::OP_RDATA, '0);
		$display("test byte done");
		wide = 1'b1;
		send(fpi_pkg::OP_CMD, 16'($urandom) & 16'h007f);
		repeat (4) send(fpi_pkg::OP_ADDR, 16'($urandom));
		repeat (2) send(fpi_pkg::OP_WDATA, 16'($urandom));
		repeat (2) send(fpi_pkg::OP_RDATA, '0);
		$display("test word done");
		wpr = 1'b0;
		send(fpi_pkg::OP_CMD, 16'h0080);
		repeat (150) @(negedge clk);
		check({17'h0_0000, busy}, 18'h0_0000);
		wpr = 1'b1;
		send(fpi_pkg::OP_CMD, 16'h0080);
		n = 0;
		while (!busy && n < 100) begin
			@(negedge clk);
			n++;
		end
		check({17'h0_0000, busy}, 18'h0_0001);
		$display("test busy done");
		rr = 1'b0;
		send(fpi_pkg::OP_CMD, 16'h0000);
		repeat (fpi_pkg::FIFO_DEPTH) send(fpi_pkg::OP_RDATA, '0);
		repeat (30) @(negedge clk);
		check({17'h0_0000, ready}, 18'h0_0000);
		rr = 1'b1;
		repeat (40) @(negedge clk);
		check(18'(rd_q.size()), 18'h0_0000);
		$display("test fifo done");
		complete_run();
	end
	initial begin
		#200000;
		errors++;
		complete_run();
	end
endmodule
bind fpi_host fpi_host_asserts u_fpi_host_asserts (.i_ref_clk(i_ref_clk),
	.i_rst(i_rst), .i_wp_release(i_wp_release), .o_req_ready(o_req_ready),
	.o_busy(o_busy), .o_ctl(o_ctl), .o_io(o_io), .o_io_oe_n(o_io_oe_n));
